//--- configurable_fifo_partition_regs.vh
/*
  Register map, field layout, reset values and sizing constants for the
  configurable FIFO partition block.
  Assumes a 32-bit register port with byte addresses and a 250 MHz clock.
*/
`ifndef CONFIGURABLE_FIFO_PARTITION_REGS_VH
`define CONFIGURABLE_FIFO_PARTITION_REGS_VH

// register byte addresses
`define ADDR_HARDWARE_CONFIGURATION      8'h74
`define ADDR_RX_FIFO_INF 8'h7c
`define ADDR_TX_FIFO_INF 8'h80
`define ADDR_RX_DROP     8'ha0

// hardware_configuration fields
`define CFG_SOFTWARE_RESET_BIT_BIT     0
`define CFG_RESET_TIMEOUT_FLAG_BIT  1
`define CFG_KEEP_BIT     2
`define CFG_SZ_LSB       16
`define CFG_SZ_MSB       19

// reset values and size field limits
`define CFG_SZ_RESET     4'h5
`define CFG_KEEP_RESET   1'b0
`define CFG_SZ_MIN       4'h2
`define CFG_SZ_MAX       4'he

// sizes in 32-bit words
`define TOTAL_WORDS      13'h1000
`define TXS_WORDS        13'h0080
`define RXD_FULL_MARGIN  13'h0004
`define TX_MIL_WORDS     13'h0200
`define RX_MIL_WORDS     13'h0020

// partition selectors
`define PART_TXD         2'h0
`define PART_TXS         2'h1
`define PART_RXD         2'h2
`define PART_RXS         2'h3

// soft reset timeout
`define SOFTWARE_RESET_BIT_TIMEOUT_NS  1000
`define CLK_MHZ          250
`define SOFTWARE_RESET_BIT_TIMEOUT_CYC ((`SOFTWARE_RESET_BIT_TIMEOUT_NS * `CLK_MHZ) / 1000)

`endif

//--- configurable_fifo_partition.v
/*
  Configurable FIFO partition of a 16 KB packet buffer: level accounting of
  the four host FIFOs, the fixed MAC interface layer buffers, the dropped
  frame counter, soft reset with timeout and the first-read write gate.
  Assumes host and MAC strobes are synchronous to clk; phy_clk_running and
  pm_wake are asynchronous pins.
*/
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "configurable_fifo_partition_regs.vh"

// Behaviour
// - soft reset with PHY clocks stopped is abandoned; timeout flag bit 1 set
// - writing one to bit 0 resets all control and status state except cfg_keep
// - soft reset spares the bits marked exempt from soft reset
// - soft reset clears latched transmit and receive error flags
// - the software reset bit clears itself
// - writes are ignored until one read after any reset or wake
// - TX allocation includes a fixed 128-word status FIFO; data gets rest
// - TX data space holds command words and payload alike
// - RX allocation is 16384 bytes minus TX allocation
// - RX status FIFO is one sixteenth of RX allocation
// - RX data FIFO counts as full four words before its size
// - fixed 2 KB transmit and 128 byte receive interface buffers
// - transmit interface buffer refills from TX data FIFO as space frees
// - receive data goes MAC, interface buffer, RX data FIFO
// - interface buffer overrun drops frames, counting once per frame
// - host levels exclude interface buffer contents
module configurable_fifo_partition (
  input wire clk,
  input wire rst_n,
  input wire [7:0] addr,
  input wire [31:0] wr_data,
  input wire wr_en,
  input wire rd_en,
  output reg [31:0] rd_data,
  input wire tx_data_push,
  input wire tx_status_pop,
  input wire rx_data_pop,
  input wire rx_status_pop,
  input wire mac_tx_pop,
  input wire mac_tx_status,
  input wire mac_rx_valid,
  input wire mac_rx_last,
  input wire phy_clk_running,
  input wire pm_wake,
  output reg mac_tx_avail,
  output reg transmit_error_flag,
  output reg receive_error_flag,
  output reg soft_reset_busy
);

  localparam S_IDLE = 1'b0;
  localparam S_WAIT = 1'b1;
  localparam [15:0] TIMEOUT_CYC = `SOFTWARE_RESET_BIT_TIMEOUT_CYC;

  // size of one partition in words from the allocation field
  function [12:0] part_words;
    input [3:0] sz;
    input [1:0] sel;
    reg [12:0] tx_total;
    reg [12:0] rx_total;
    begin
      tx_total = {1'b0, sz, 8'h00};
      rx_total = `TOTAL_WORDS - tx_total;
      case (sel)
        `PART_TXD: part_words = tx_total - `TXS_WORDS;
        `PART_TXS: part_words = `TXS_WORDS;
        `PART_RXS: part_words = {4'h0, rx_total[12:4]};
        default: part_words = rx_total - {4'h0, rx_total[12:4]};
      endcase
    end
  endfunction

  // pin synchronisers
  reg phy_meta, phy_ok;
  reg wake_meta, wake_sync, wake_prev;

  // control state
  reg state;
  reg [15:0] software_reset_bit_cnt;
  reg software_reset_bit_bit, reset_timeout_flag, cfg_keep;
  reg [3:0] tx_size;
  reg read_seen;
  reg [31:0] drop_count;
  reg dropping;

  // fifo levels in words
  reg [12:0] txd_used, txs_used, rxd_used, rxs_used, tx_mil, rx_mil;

  wire [12:0] txd_size = part_words(tx_size, `PART_TXD);
  wire [12:0] txs_size = part_words(tx_size, `PART_TXS);
  wire [12:0] rxd_size = part_words(tx_size, `PART_RXD);
  wire [12:0] rxs_size = part_words(tx_size, `PART_RXS);

  // bus decode
  wire wr_ok = wr_en && read_seen;
  wire cfg_wr = wr_ok && (addr == `ADDR_HARDWARE_CONFIGURATION);
  wire software_reset_bit_req = cfg_wr && wr_data[`CFG_SOFTWARE_RESET_BIT_BIT] && (state == S_IDLE);
  wire wake_edge = wake_sync && !wake_prev;

  // soft reset outcome
  wire soft_rst = (state == S_WAIT) && phy_ok;
  wire software_reset_bit_abort = (state == S_WAIT) && !phy_ok && (software_reset_bit_cnt == TIMEOUT_CYC - 16'h0001);

  // transmit path moves
  wire txd_in = tx_data_push && (txd_used < txd_size);
  wire tx_move = (txd_used != 13'h0000) && (tx_mil < `TX_MIL_WORDS);
  wire tx_out = mac_tx_pop && (tx_mil != 13'h0000);
  wire txs_in = mac_tx_status && (txs_used < txs_size);
  wire txs_out = tx_status_pop && (txs_used != 13'h0000);

  // receive path moves
  wire rxd_full = (rxd_used + `RXD_FULL_MARGIN) >= rxd_size;
  wire rx_take = mac_rx_valid && !dropping && (rx_mil < `RX_MIL_WORDS);
  wire rx_over = mac_rx_valid && !dropping && (rx_mil == `RX_MIL_WORDS);
  wire rx_move = (rx_mil != 13'h0000) && !rxd_full;
  wire rxd_out = rx_data_pop && (rxd_used != 13'h0000);
  wire rxs_in = rx_take && mac_rx_last && (rxs_used < rxs_size);
  wire rxs_out = rx_status_pop && (rxs_used != 13'h0000);

  // error events
  wire tx_err_evt = (tx_data_push && !txd_in) || (tx_status_pop && !txs_out);
  wire rx_err_evt = (rx_data_pop && !rxd_out) || (rx_status_pop && !rxs_out);

  // next values of the levels
  reg [12:0] next_tx_mil, next_rx_mil;
  always @* begin
    next_tx_mil = tx_mil;
    if (tx_move && !tx_out)
      next_tx_mil = tx_mil + 13'h0001;
    else if (!tx_move && tx_out)
      next_tx_mil = tx_mil - 13'h0001;
    next_rx_mil = rx_mil;
    if (rx_take && !rx_move)
      next_rx_mil = rx_mil + 13'h0001;
    else if (!rx_take && rx_move)
      next_rx_mil = rx_mil - 13'h0001;
  end

  // two flop synchronisers for the asynchronous pins
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phy_meta <= 1'b0;
      phy_ok <= 1'b0;
      wake_meta <= 1'b0;
      wake_sync <= 1'b0;
      wake_prev <= 1'b0;
    end else begin
      phy_meta <= phy_clk_running;
      phy_ok <= phy_meta;
      wake_meta <= pm_wake;
      wake_sync <= wake_meta;
      wake_prev <= wake_sync;
    end
  end

  // soft reset sequencer
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      software_reset_bit_cnt <= 16'h0000;
      software_reset_bit_bit <= 1'b0;
      reset_timeout_flag <= 1'b0;
    end else begin
      case (state)
        S_IDLE: begin
          software_reset_bit_cnt <= 16'h0000;
          if (software_reset_bit_req) begin
            state <= S_WAIT;
            software_reset_bit_bit <= 1'b1;
            reset_timeout_flag <= 1'b0;
          end
        end
        S_WAIT: begin
          software_reset_bit_cnt <= software_reset_bit_cnt + 16'h0001;
          if (soft_rst) begin
            state <= S_IDLE;
            software_reset_bit_bit <= 1'b0;
          end else if (software_reset_bit_abort) begin
            state <= S_IDLE;
            software_reset_bit_bit <= 1'b0;
            reset_timeout_flag <= 1'b1;
          end
        end
        default: begin
          state <= S_IDLE;
          software_reset_bit_bit <= 1'b0;
        end
      endcase
    end
  end

  // configuration, write gate and error flags
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_size <= `CFG_SZ_RESET;
      cfg_keep <= `CFG_KEEP_RESET;
      read_seen <= 1'b0;
      transmit_error_flag <= 1'b0;
      receive_error_flag <= 1'b0;
    end else begin
      // a read arms writes; reset or wake disarms them
      if (rd_en)
        read_seen <= 1'b1;
      else if (soft_rst || wake_edge)
        read_seen <= 1'b0;
      if (soft_rst) begin
        tx_size <= `CFG_SZ_RESET;
      end else if (cfg_wr) begin
        cfg_keep <= wr_data[`CFG_KEEP_BIT];
        if (wr_data[`CFG_SZ_MSB:`CFG_SZ_LSB] >= `CFG_SZ_MIN &&
            wr_data[`CFG_SZ_MSB:`CFG_SZ_LSB] <= `CFG_SZ_MAX)
          tx_size <= wr_data[`CFG_SZ_MSB:`CFG_SZ_LSB];
      end
      // new events win over the soft reset clear
      transmit_error_flag <= (transmit_error_flag && !soft_rst) || tx_err_evt;
      receive_error_flag <= (receive_error_flag && !soft_rst) || rx_err_evt;
    end
  end

  // transmit levels
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txd_used <= 13'h0000;
      txs_used <= 13'h0000;
      tx_mil <= 13'h0000;
      mac_tx_avail <= 1'b0;
    end else if (soft_rst) begin
      txd_used <= 13'h0000;
      txs_used <= 13'h0000;
      tx_mil <= 13'h0000;
      mac_tx_avail <= 1'b0;
    end else begin
      if (txd_in && !tx_move)
        txd_used <= txd_used + 13'h0001;
      else if (!txd_in && tx_move)
        txd_used <= txd_used - 13'h0001;
      if (txs_in && !txs_out)
        txs_used <= txs_used + 13'h0001;
      else if (!txs_in && txs_out)
        txs_used <= txs_used - 13'h0001;
      tx_mil <= next_tx_mil;
      mac_tx_avail <= (next_tx_mil != 13'h0000);
    end
  end

  // receive levels and dropped frame counting
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxd_used <= 13'h0000;
      rxs_used <= 13'h0000;
      rx_mil <= 13'h0000;
      dropping <= 1'b0;
      drop_count <= 32'h0000_0000;
    end else if (soft_rst) begin
      rxd_used <= 13'h0000;
      rxs_used <= 13'h0000;
      rx_mil <= 13'h0000;
      dropping <= 1'b0;
      drop_count <= 32'h0000_0000;
    end else begin
      if (rx_move && !rxd_out)
        rxd_used <= rxd_used + 13'h0001;
      else if (!rx_move && rxd_out)
        rxd_used <= rxd_used - 13'h0001;
      if (rxs_in && !rxs_out)
        rxs_used <= rxs_used + 13'h0001;
      else if (!rxs_in && rxs_out)
        rxs_used <= rxs_used - 13'h0001;
      rx_mil <= next_rx_mil;
      // overrun discards the rest of the frame, one count per frame
      if (rx_over) begin
        drop_count <= drop_count + 32'h0000_0001;
        dropping <= !mac_rx_last;
      end else if (dropping && mac_rx_valid && mac_rx_last) begin
        dropping <= 1'b0;
      end
    end
  end

  // register read data, valid the cycle after the read strobe
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 32'h0000_0000;
    end else if (rd_en) begin
      case (addr)
        `ADDR_HARDWARE_CONFIGURATION:
          rd_data <= {12'h000, tx_size, 13'h0000, cfg_keep, reset_timeout_flag, software_reset_bit_bit};
        `ADDR_RX_FIFO_INF:
          rd_data <= {8'h00, rxs_used[7:0], 1'b0, rxd_used, 2'b00};
        `ADDR_TX_FIFO_INF:
          rd_data <= {8'h00, txs_used[7:0], 1'b0, txd_size - txd_used, 2'b00};
        `ADDR_RX_DROP:
          rd_data <= drop_count;
        default:
          rd_data <= 32'h0000_0000;
      endcase
    end else begin
      rd_data <= 32'h0000_0000;
    end
  end

  // busy indication for the soft reset in progress
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      soft_reset_busy <= 1'b0;
    else
      soft_reset_busy <= (state == S_IDLE) ? software_reset_bit_req : !(soft_rst || software_reset_bit_abort);
  end

endmodule // configurable_fifo_partition

`default_nettype wire

//--- partition_monitor.sv
/* Port checker for the FIFO partition block.
   Assumes one clock and an active-low asynchronous reset. */
`timescale 1ns/1ps
`default_nettype none
`include "configurable_fifo_partition_regs.vh"
module partition_monitor (
  input wire clk,
  input wire rst_n,
  input wire [7:0] addr,
  input wire [31:0] wr_data,
  input wire wr_en,
  input wire rd_en,
  input wire [31:0] rd_data,
  input wire tx_data_push,
  input wire tx_status_pop,
  input wire rx_data_pop,
  input wire rx_status_pop,
  input wire phy_clk_running,
  input wire transmit_error_flag,
  input wire receive_error_flag,
  input wire soft_reset_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // soft reset started with phy clocks stopped for a while
  sequence s_phy_down;
    $rose(soft_reset_busy) && !$past(phy_clk_running, 2) && !$past(phy_clk_running)
      && !phy_clk_running ##1 (!phy_clk_running)[*7];
  endsequence
  property p_software_reset_bit_wait; s_phy_down |-> soft_reset_busy; endproperty
  a_software_reset_bit_wait: assert property (p_software_reset_bit_wait) else $error("reset done without phy");
  property p_software_reset_bit_cause;
    $rose(soft_reset_busy) |-> $past(wr_en) && $past(wr_data[0]) && $past(addr) == `ADDR_HARDWARE_CONFIGURATION;
  endproperty
  a_software_reset_bit_cause: assert property (p_software_reset_bit_cause) else $error("busy without request");
  property p_software_reset_bit_ends; soft_reset_busy |-> ##[1:300] !soft_reset_busy; endproperty
  a_software_reset_bit_ends: assert property (p_software_reset_bit_ends) else $error("reset bit stuck");
  property p_err_clear;
    $fell(soft_reset_busy) && $past(phy_clk_running, 3) |-> !transmit_error_flag && !receive_error_flag;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("errors kept over reset");
  property p_tx_sticky; transmit_error_flag && !soft_reset_busy |=> transmit_error_flag; endproperty
  a_tx_sticky: assert property (p_tx_sticky) else $error("tx error lost");
  property p_tx_cause;
    $rose(transmit_error_flag) |-> $past(tx_data_push) || $past(tx_status_pop);
  endproperty
  a_tx_cause: assert property (p_tx_cause) else $error("tx error uncaused");
  property p_rx_cause;
    $rose(receive_error_flag) |-> $past(rx_data_pop) || $past(rx_status_pop);
  endproperty
  a_rx_cause: assert property (p_rx_cause) else $error("rx error uncaused");
  property p_rd_idle; !rd_en |=> rd_data == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
endmodule // partition_monitor
bind configurable_fifo_partition partition_monitor mon (.*);
`default_nettype wire

//--- mac_model.sv
/* Behavioural MAC on the line side of the partition block.
   Assumes word pulses synchronous to clk. */
`timescale 1ns/1ps
`default_nettype none
module mac_model (
  input wire clk,
  input wire mac_tx_avail,
  output logic mac_tx_pop,
  output logic mac_tx_status,
  output logic mac_rx_valid,
  output logic mac_rx_last
);
  initial {mac_tx_pop, mac_tx_status, mac_rx_valid, mac_rx_last} = 4'h0;
  // slow drain: a word every other cycle, status a cycle later
  always @(posedge clk) begin
    mac_tx_pop <= mac_tx_avail && !mac_tx_pop;
    mac_tx_status <= mac_tx_pop;
  end
  // one received frame of n back-to-back words
  task send(input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      mac_rx_valid <= 1'b1;
      mac_rx_last <= (k == n - 1);
    end
    @(posedge clk);
    {mac_rx_valid, mac_rx_last} <= 2'h0;
  endtask
endmodule // mac_model
`default_nettype wire

//--- configurable_fifo_partition_tb.sv
/* Self-checking bench for the FIFO partition block.
   Assumes the design, the MAC model and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "configurable_fifo_partition_regs.vh"
module configurable_fifo_partition_tb;
  logic clk = 0, rst_n = 0, wr_en = 0, rd_en = 0, tx_data_push = 0, tx_status_pop = 0;
  logic rx_data_pop = 0, rx_status_pop = 0, phy_clk_running = 1, pm_wake = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0, r;
  wire [31:0] rd_data;
  wire mac_tx_pop, mac_tx_status, mac_rx_valid, mac_rx_last, mac_tx_avail;
  wire transmit_error_flag, receive_error_flag, soft_reset_busy;
  int n_errors = 0, check_count = 0, seed = 75384, len, i;
  configurable_fifo_partition DUT (.*);
  mac_model mac (.*);
  initial forever #2 clk = ~clk;
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {addr, wr_data, wr_en} <= {a, d, 1'b1};
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk);
    {addr, rd_en} <= {a, 1'b1};
    @(posedge clk);
    rd_en <= 1'b0;
    #1 r = rd_data;
  endtask
  task wait_idle;
    #1 i = 0;
    while (soft_reset_busy === 1'b1 && i < 300) begin
      @(posedge clk);
      #1 i++;
    end
    chk(soft_reset_busy, 0);
  endtask
  function logic [31:0] txfree(int sz);
    return sz * 1024 - 512;
  endfunction
  task print_verdict;
    if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #50000;
    n_errors++;
    print_verdict;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    wr(`ADDR_HARDWARE_CONFIGURATION, 32'h0008_0000);
    rd(`ADDR_HARDWARE_CONFIGURATION);
    chk(r[19:16], 5);
    rd(`ADDR_TX_FIFO_INF);
    chk(r, txfree(5));
    @(posedge clk) rx_data_pop <= 1'b1;
    @(posedge clk) rx_data_pop <= 1'b0;
    @(posedge clk) #1 chk(receive_error_flag, 1);
    // sweep sizes, then reserved codes 15, 0, 1
    for (int s = 2; s < 18; s++) begin
      wr(`ADDR_HARDWARE_CONFIGURATION, ((s & 15) << 16) | 4);
      rd(`ADDR_TX_FIFO_INF);
      chk(r, txfree(s > 14 ? 14 : s));
    end
    len = 1 + ($random(seed) & 3);
    mac.send(len);
    repeat (4) @(posedge clk);
    rd(`ADDR_RX_FIFO_INF);
    chk(r, 32'h10000 | (len * 4));
    repeat (6) mac.send(100);
    mac.send(3);
    repeat (4) @(posedge clk);
    rd(`ADDR_RX_FIFO_INF);
    chk(r[15:0], 16'h0770);
    rd(`ADDR_RX_DROP);
    chk(r, 2);
    repeat (3) begin
      @(posedge clk) tx_data_push <= 1'b1;
      @(posedge clk) tx_data_push <= 1'b0;
      @(posedge clk) #1 chk(mac_tx_avail, 1);
    end
    repeat (20) @(posedge clk);
    rd(`ADDR_TX_FIFO_INF);
    chk(r, 32'h30000 | txfree(14));
    @(posedge clk) tx_status_pop <= 1'b1;
    repeat (4) @(posedge clk);
    tx_status_pop <= 1'b0;
    @(posedge clk) #1 chk(transmit_error_flag, 1);
    phy_clk_running <= 1'b0;
    wr(`ADDR_HARDWARE_CONFIGURATION, 32'h000e_0005);
    wait_idle;
    rd(`ADDR_HARDWARE_CONFIGURATION);
    chk(r[2:0], 3'b110);
    phy_clk_running <= 1'b1;
    repeat (4) @(posedge clk);
    wr(`ADDR_HARDWARE_CONFIGURATION, 32'h000e_0005);
    wait_idle;
    chk({transmit_error_flag, receive_error_flag}, 0);
    wr(`ADDR_HARDWARE_CONFIGURATION, 32'h0008_0000);
    rd(`ADDR_HARDWARE_CONFIGURATION);
    chk({r[19:16], r[2:0]}, 7'h2c);
    rd(`ADDR_RX_DROP);
    chk(r, 0);
    pm_wake <= 1'b1;
    repeat (4) @(posedge clk);
    wr(`ADDR_HARDWARE_CONFIGURATION, 32'h0008_0000);
    pm_wake <= 1'b0;
    rd(`ADDR_HARDWARE_CONFIGURATION);
    chk(r[19:16], 5);
    print_verdict;
  end
endmodule // configurable_fifo_partition_tb
`default_nettype wire
